// ### rtl/rci_defs.svh
// Constants for the reflow counter and interlock block
// Contract
// - Seven-digit usage counter, preloadable, wraps to zero.
// - Good counter counts good processes only, same wrap.
// - Good means within every enabled limit.
// - Enabled cleaning countdown at zero raises alarm.
// - Cleaning stop action blocks processes, relay inactive.
// - Cleaning continue action allows processes, relay active.
// - Continue shows cleaning message after each process.
// - Countdown presets accept zero up to 999999.
// - Enabled replacement countdown at zero raises alarm.
// - Replacement stop action blocks processes, relay inactive.
// - Replacement continue allows processes, message each process.
// - Profile index stays between 1 and 63.
// - Profile keys act only in graph or data view.
// - Profile key in data view returns to graph.
// - Heat start only in graph or data view.
// - Data view shows last completed cycle values.
// - Entering commit views writes edits to flash.
`ifndef RCI_DEFS_SVH
`define RCI_DEFS_SVH

`define RCI_OFF_CTRL 8'h00
`define RCI_OFF_USAGE 8'h04
`define RCI_OFF_GOOD 8'h08
`define RCI_OFF_CLEAN 8'h0c
`define RCI_OFF_RENEW 8'h10
`define RCI_OFF_PROFILE 8'h14
`define RCI_OFF_STATUS 8'h18
`define RCI_OFF_LAST_TIME 8'h1c
`define RCI_OFF_LAST_TEMP 8'h20
`define RCI_OFF_IRQ_STAT 8'h24
`define RCI_OFF_IRQ_MASK 8'h28

`define RCI_CTRL_CLEAN_EN 0
`define RCI_CTRL_SERVICE_ACT 1
`define RCI_CTRL_RENEW_EN 2
`define RCI_CTRL_RENEW_ACT 3
`define RCI_CTRL_PEAK_EN 4
`define RCI_CTRL_AVG_EN 5
`define RCI_CTRL_ENV_EN 6

`define RCI_IRQ_PROC 0
`define RCI_IRQ_CLEAN 1
`define RCI_IRQ_RENEW 2
`define RCI_IRQ_SAVED 3

`define RCI_CTRL_RST 7'h70
`define RCI_PROFILE_RST 6'h01
`define RCI_USAGE_MAX 24'h98967f
`define RCI_REM_MAX 20'hf423f
`define RCI_REM_RST 20'hf423f
`define RCI_PROFILE_MIN 6'h01

`define RCI_RESP_OKAY 2'h0
`define RCI_RESP_SLVERR 2'h2

`endif

// ### rtl/rci_pkg.sv
// Types for the reflow counter and interlock block
package rci_pkg;

  typedef enum logic [2:0] {
    VIEW_GRAPH,
    VIEW_DATA,
    VIEW_COUNTERS,
    VIEW_HEATRATE,
    VIEW_SETUP,
    VIEW_MENU
  } rci_view_t;

  typedef enum logic {
    SAVE_IDLE,
    SAVE_BUSY
  } rci_save_t;

  typedef struct packed {
    logic peak_ok;
    logic avg_ok;
    logic env_ok;
    logic [15:0] time_val;
    logic [15:0] temp_val;
  } rci_proc_t;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rci_bus_t;

  typedef struct packed {
    rci_bus_t bus;
    logic [6:0] ctrl;
    logic [23:0] usage;
    logic [23:0] good;
    logic [19:0] clean_rem;
    logic [19:0] renew_rem;
    logic [5:0] profile;
    rci_view_t view;
    logic dirty;
    rci_save_t save;
    logic [15:0] last_time;
    logic [15:0] last_temp;
    logic clean_msg;
    logic renew_msg;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
  } rci_state_t;

endpackage

// ### rtl/rci_top.sv
// Reflow counter, interlock, profile select and flash commit
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rci_defs.svh"

module rci_top
  import rci_pkg::*;
#(
  parameter int PROFILE_MAX = 63
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  input wire logic I_PROC_DONE,
  input wire rci_proc_t I_PROC,
  input wire logic I_KEY_UP,
  input wire logic I_KEY_DOWN,
  input wire logic I_VIEW_SEL,
  input wire rci_view_t I_VIEW_CODE,
  input wire logic I_START_REQ,
  output logic O_START_GRANT,
  output logic O_SYS_READY,
  output logic O_CLEAN_MSG,
  output logic O_RENEW_MSG,
  output logic O_FLASH_REQ,
  input wire logic I_FLASH_DONE,
  output logic O_SAVING,
  output logic O_IRQ
);

  if (PROFILE_MAX < 1 || PROFILE_MAX > 63) begin : g_chk
    $error("PROFILE_MAX must lie between 1 and 63");
  end

  localparam logic [5:0] PMAX = 6'(PROFILE_MAX);

  function automatic logic is_run_view(input rci_view_t v);
    return (v == VIEW_GRAPH) || (v == VIEW_DATA);
  endfunction

  function automatic logic is_commit_view(input rci_view_t v);
    return v != VIEW_MENU;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  rci_state_t st;
  rci_state_t next_st;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_val;
  logic good;
  logic clean_due;
  logic renew_due;
  logic blocked;
  logic [31:0] rd_val;
  logic rd_ok;
  logic go_graph;
  logic [19:0] next_clean;
  logic [19:0] next_renew;
  logic [3:0] irq_set;

  assign wr_en = st.bus.aw_got && st.bus.w_got && !st.bus.bvalid;
  assign wr_addr = st.bus.awaddr;
  assign clean_due = st.ctrl[`RCI_CTRL_CLEAN_EN] && (st.clean_rem == '0);
  assign renew_due = st.ctrl[`RCI_CTRL_RENEW_EN] && (st.renew_rem == '0);
  assign blocked = (clean_due && !st.ctrl[`RCI_CTRL_SERVICE_ACT])
                 || (renew_due && !st.ctrl[`RCI_CTRL_RENEW_ACT]);
  assign good = (!st.ctrl[`RCI_CTRL_PEAK_EN] || I_PROC.peak_ok)
             && (!st.ctrl[`RCI_CTRL_AVG_EN] || I_PROC.avg_ok)
             && (!st.ctrl[`RCI_CTRL_ENV_EN] || I_PROC.env_ok);
  assign go_graph = (I_KEY_UP || I_KEY_DOWN) && (st.view == VIEW_DATA);

  // Read data mux
  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    case (I_AXI_ARADDR)
      `RCI_OFF_CTRL: rd_val = {25'h0, st.ctrl};
      `RCI_OFF_USAGE: rd_val = {8'h0, st.usage};
      `RCI_OFF_GOOD: rd_val = {8'h0, st.good};
      `RCI_OFF_CLEAN: rd_val = {12'h0, st.clean_rem};
      `RCI_OFF_RENEW: rd_val = {12'h0, st.renew_rem};
      `RCI_OFF_PROFILE: rd_val = {26'h0, st.profile};
      `RCI_OFF_STATUS: rd_val = {24'h0, st.dirty, blocked, st.renew_msg,
                                 st.clean_msg, O_SAVING, st.view};
      `RCI_OFF_LAST_TIME: rd_val = {16'h0, st.last_time};
      `RCI_OFF_LAST_TEMP: rd_val = {16'h0, st.last_temp};
      `RCI_OFF_IRQ_STAT: rd_val = {28'h0, st.irq_stat};
      `RCI_OFF_IRQ_MASK: rd_val = {28'h0, st.irq_mask};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    wr_val = 32'h0;
    next_clean = st.clean_rem;
    next_renew = st.renew_rem;
    irq_set = 4'h0;
    // Bus handshakes
    if (I_AXI_AWVALID && O_AXI_AWREADY) begin
      next_st.bus.aw_got = 1'b1;
      next_st.bus.awaddr = I_AXI_AWADDR;
    end
    if (I_AXI_WVALID && O_AXI_WREADY) begin
      next_st.bus.w_got = 1'b1;
      next_st.bus.wdata = I_AXI_WDATA;
      next_st.bus.wstrb = I_AXI_WSTRB;
    end
    if (st.bus.bvalid && I_AXI_BREADY) begin
      next_st.bus.bvalid = 1'b0;
    end
    if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      next_st.bus.rvalid = 1'b1;
      next_st.bus.rdata = rd_val;
      next_st.bus.rresp = rd_ok ? `RCI_RESP_OKAY : `RCI_RESP_SLVERR;
    end else if (st.bus.rvalid && I_AXI_RREADY) begin
      next_st.bus.rvalid = 1'b0;
    end
    // Process completion
    if (I_PROC_DONE) begin
      next_st.usage = (st.usage >= `RCI_USAGE_MAX) ? 24'h0
                    : st.usage + 24'h1;
      if (good) begin
        next_st.good = (st.good >= `RCI_USAGE_MAX) ? 24'h0
                     : st.good + 24'h1;
      end
      next_st.last_time = I_PROC.time_val;
      next_st.last_temp = I_PROC.temp_val;
      if (st.ctrl[`RCI_CTRL_CLEAN_EN] && st.clean_rem != '0) begin
        next_clean = st.clean_rem - 20'h1;
      end
      if (st.ctrl[`RCI_CTRL_RENEW_EN] && st.renew_rem != '0) begin
        next_renew = st.renew_rem - 20'h1;
      end
      irq_set[`RCI_IRQ_PROC] = 1'b1;
      if (st.ctrl[`RCI_CTRL_CLEAN_EN] && next_clean == '0) begin
        next_st.clean_msg = 1'b1;
        irq_set[`RCI_IRQ_CLEAN] = 1'b1;
      end
      if (st.ctrl[`RCI_CTRL_RENEW_EN] && next_renew == '0) begin
        next_st.renew_msg = 1'b1;
        irq_set[`RCI_IRQ_RENEW] = 1'b1;
      end
    end
    next_st.clean_rem = next_clean;
    next_st.renew_rem = next_renew;
    // Profile keys and views
    if (I_KEY_UP || I_KEY_DOWN) begin
      if (st.view == VIEW_DATA) begin
        next_st.view = VIEW_GRAPH;
      end else if (st.view == VIEW_GRAPH) begin
        if (I_KEY_UP && !I_KEY_DOWN) begin
          next_st.profile = (st.profile >= PMAX) ? `RCI_PROFILE_MIN
                          : st.profile + 6'h1;
          next_st.dirty = 1'b1;
        end else if (I_KEY_DOWN && !I_KEY_UP) begin
          next_st.profile = (st.profile <= `RCI_PROFILE_MIN) ? PMAX
                          : st.profile - 6'h1;
          next_st.dirty = 1'b1;
        end
      end
    end
    if (I_VIEW_SEL) begin
      next_st.view = I_VIEW_CODE;
    end
    // Flash commit on entering a commit view
    if (st.save == SAVE_BUSY) begin
      if (I_FLASH_DONE) begin
        next_st.save = SAVE_IDLE;
        irq_set[`RCI_IRQ_SAVED] = 1'b1;
      end
    end else if (st.dirty && ((I_VIEW_SEL && is_commit_view(I_VIEW_CODE))
                              || go_graph)) begin
      next_st.save = SAVE_BUSY;
      next_st.dirty = 1'b0;
    end
    // Events set status bits; set wins over a clear
    next_st.irq_stat = st.irq_stat | irq_set;
    // Register writes
    if (wr_en) begin
      next_st.bus.aw_got = 1'b0;
      next_st.bus.w_got = 1'b0;
      next_st.bus.bvalid = 1'b1;
      next_st.bus.bresp = `RCI_RESP_OKAY;
      next_st.dirty = 1'b1;
      case (wr_addr)
        `RCI_OFF_CTRL: begin
          wr_val = merge({25'h0, st.ctrl}, st.bus.wdata, st.bus.wstrb);
          next_st.ctrl = wr_val[6:0];
          if (!wr_val[`RCI_CTRL_CLEAN_EN]) begin
            next_st.clean_msg = 1'b0;
          end
          if (!wr_val[`RCI_CTRL_RENEW_EN]) begin
            next_st.renew_msg = 1'b0;
          end
        end
        `RCI_OFF_USAGE: begin
          wr_val = merge({8'h0, st.usage}, st.bus.wdata, st.bus.wstrb);
          next_st.usage = (wr_val > 32'(`RCI_USAGE_MAX)) ? `RCI_USAGE_MAX
                        : wr_val[23:0];
        end
        `RCI_OFF_GOOD: begin
          wr_val = merge({8'h0, st.good}, st.bus.wdata, st.bus.wstrb);
          next_st.good = (wr_val > 32'(`RCI_USAGE_MAX)) ? `RCI_USAGE_MAX
                       : wr_val[23:0];
        end
        `RCI_OFF_CLEAN: begin
          wr_val = merge({12'h0, st.clean_rem}, st.bus.wdata, st.bus.wstrb);
          next_st.clean_rem = (wr_val > 32'(`RCI_REM_MAX)) ? `RCI_REM_MAX
                            : wr_val[19:0];
          next_st.clean_msg = 1'b0;
        end
        `RCI_OFF_RENEW: begin
          wr_val = merge({12'h0, st.renew_rem}, st.bus.wdata, st.bus.wstrb);
          next_st.renew_rem = (wr_val > 32'(`RCI_REM_MAX)) ? `RCI_REM_MAX
                            : wr_val[19:0];
          next_st.renew_msg = 1'b0;
        end
        `RCI_OFF_PROFILE: begin
          wr_val = merge({26'h0, st.profile}, st.bus.wdata, st.bus.wstrb);
          if (wr_val >= 32'(`RCI_PROFILE_MIN) && wr_val <= 32'(PMAX)) begin
            next_st.profile = wr_val[5:0];
          end
        end
        `RCI_OFF_IRQ_STAT: begin
          next_st.dirty = st.dirty;
          next_st.irq_stat = (st.irq_stat
                             & ~(st.bus.wdata[3:0] & {4{st.bus.wstrb[0]}}))
                           | irq_set;
        end
        `RCI_OFF_IRQ_MASK: begin
          next_st.dirty = st.dirty;
          wr_val = merge({28'h0, st.irq_mask}, st.bus.wdata, st.bus.wstrb);
          next_st.irq_mask = wr_val[3:0];
        end
        default: begin
          next_st.dirty = st.dirty;
          next_st.bus.bresp = `RCI_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      st <= '0;
      st.ctrl <= `RCI_CTRL_RST;
      st.clean_rem <= `RCI_REM_RST;
      st.renew_rem <= `RCI_REM_RST;
      st.profile <= `RCI_PROFILE_RST;
      st.view <= VIEW_GRAPH;
      st.save <= SAVE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign O_AXI_AWREADY = !st.bus.aw_got && !st.bus.bvalid;
  assign O_AXI_WREADY = !st.bus.w_got && !st.bus.bvalid;
  assign O_AXI_BVALID = st.bus.bvalid;
  assign O_AXI_BRESP = st.bus.bresp;
  assign O_AXI_ARREADY = !st.bus.rvalid;
  assign O_AXI_RVALID = st.bus.rvalid;
  assign O_AXI_RDATA = st.bus.rdata;
  assign O_AXI_RRESP = st.bus.rresp;
  assign O_START_GRANT = I_START_REQ && is_run_view(st.view)
                      && !blocked && (st.save == SAVE_IDLE);
  assign O_SYS_READY = !blocked;
  assign O_CLEAN_MSG = st.clean_msg;
  assign O_RENEW_MSG = st.renew_msg;
  assign O_FLASH_REQ = (st.save == SAVE_BUSY);
  assign O_SAVING = (st.save == SAVE_BUSY);
  assign O_IRQ = |(st.irq_stat & st.irq_mask);

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  a_usage_wrap: assert property (
    I_PROC_DONE && st.usage == `RCI_USAGE_MAX
    && !(wr_en && wr_addr == `RCI_OFF_USAGE) |=> st.usage == 24'h0)
    else $error("usage counter did not wrap to zero");
  a_good_hold: assert property (
    I_PROC_DONE && !good && !(wr_en && wr_addr == `RCI_OFF_GOOD)
    |=> $stable(st.good))
    else $error("good counter moved on a bad process");
  a_stop_relay: assert property (
    clean_due && !st.ctrl[`RCI_CTRL_SERVICE_ACT]
    |-> !O_SYS_READY && !O_START_GRANT)
    else $error("cleaning stop did not block");
  a_cont_relay: assert property (
    clean_due && st.ctrl[`RCI_CTRL_SERVICE_ACT]
    && !(renew_due && !st.ctrl[`RCI_CTRL_RENEW_ACT]) |-> O_SYS_READY)
    else $error("cleaning continue dropped ready");
  a_clean_alarm: assert property (
    I_PROC_DONE && st.ctrl[`RCI_CTRL_CLEAN_EN] && st.clean_rem == 20'h1
    && !wr_en |=> O_CLEAN_MSG && st.irq_stat[`RCI_IRQ_CLEAN])
    else $error("cleaning alarm not raised");
  a_rem_dec: assert property (
    I_PROC_DONE && st.ctrl[`RCI_CTRL_RENEW_EN] && st.renew_rem != '0
    && !wr_en |=> st.renew_rem == $past(st.renew_rem) - 20'h1)
    else $error("replacement countdown did not step");
  a_profile_range: assert property (
    st.profile >= `RCI_PROFILE_MIN && st.profile <= PMAX)
    else $error("profile index out of range");
  a_key_data: assert property (
    go_graph && !I_VIEW_SEL && !wr_en
    |=> st.view == VIEW_GRAPH && $stable(st.profile))
    else $error("data view key did not return to graph");
  a_key_ignore: assert property (
    (I_KEY_UP || I_KEY_DOWN) && !is_run_view(st.view) && !wr_en
    |=> $stable(st.profile))
    else $error("profile key acted outside graph or data");
  a_start_menu: assert property (
    !is_run_view(st.view) |-> !O_START_GRANT)
    else $error("heat start granted in a menu view");
  a_commit_go: assert property (
    st.save == SAVE_IDLE && st.dirty && I_VIEW_SEL
    && is_commit_view(I_VIEW_CODE) |=> O_FLASH_REQ && O_SAVING)
    else $error("commit did not start on view change");
  a_save_hold: assert property (
    O_FLASH_REQ && !I_FLASH_DONE |=> O_SAVING)
    else $error("saving indication dropped early");
  a_last_data: assert property (
    I_PROC_DONE |=> st.last_time == $past(I_PROC.time_val))
    else $error("last cycle data not captured");
  a_good_wrap: assert property (
    I_PROC_DONE && good && st.good == `RCI_USAGE_MAX
    && !(wr_en && wr_addr == `RCI_OFF_GOOD) |=> st.good == 24'h0)
    else $error("good counter did not wrap to zero");
  a_renew_stop: assert property (
    renew_due && !st.ctrl[`RCI_CTRL_RENEW_ACT]
    |-> !O_SYS_READY && !O_START_GRANT)
    else $error("replacement stop did not block");
  a_renew_again: assert property (
    I_PROC_DONE && renew_due && !wr_en |=> O_RENEW_MSG)
    else $error("replacement message not shown after process");
  a_clean_again: assert property (
    I_PROC_DONE && clean_due && !wr_en |=> O_CLEAN_MSG)
    else $error("cleaning message not shown after process");
  a_rem_range: assert property (
    st.clean_rem <= `RCI_REM_MAX && st.renew_rem <= `RCI_REM_MAX)
    else $error("remaining count above its limit");

endmodule // rci_top

`default_nettype wire

// ### testbench/rci_flash_model.sv
// Flash store model that answers commit requests after a set delay
`timescale 1ns/1ps
`default_nettype none

module rci_flash_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_flash_req,
  input wire logic [3:0] i_delay,
  output logic o_flash_done
);
  logic [3:0] wait_cnt;

  // One done pulse per request, i_delay plus one cycles after the request rises
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wait_cnt <= 4'h0;
      o_flash_done <= 1'h0;
    end else begin
      o_flash_done <= i_flash_req && (wait_cnt == i_delay);
      if (!i_flash_req) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt != 4'hf) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // rci_flash_model
`default_nettype wire

// ### testbench/tb_reflow_counter_interlock.sv
// Self-checking bench for the reflow counter and interlock block
`timescale 1ns/1ps
`default_nettype none
`include "rci_defs.svh"
`define TB_CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("Error %s exp %0h got %0h", n, e, g); end end

module tb_reflow_counter_interlock
  import rci_pkg::*;
;
  logic clk;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdata_q;
  logic [3:0] wstrb = 4'hf, fdelay = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic bready = 1'h1, rready = 1'h1;
  logic pdone = 1'h0, kup = 1'h0, kdn = 1'h0, vsel = 1'h0, sreq = 1'h0;
  rci_proc_t proc = '0;
  rci_view_t vcode = VIEW_GRAPH;
  logic awready, wready, bvalid, arready, rvalid, grant, ready;
  logic cmsg, rmsg, freq, fdone, saving, irq;
  logic [1:0] bresp, rresp, bresp_q, rresp_q;
  int bad_count = 0, total_checks = 0;

  rci_top #(.PROFILE_MAX(63)) rci_top_inst (
    .I_REF_CLK(clk), .I_RESET_N(rst_n),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb),
    .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
    .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
    .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_PROC_DONE(pdone), .I_PROC(proc), .I_KEY_UP(kup), .I_KEY_DOWN(kdn),
    .I_VIEW_SEL(vsel), .I_VIEW_CODE(vcode), .I_START_REQ(sreq),
    .O_START_GRANT(grant), .O_SYS_READY(ready), .O_CLEAN_MSG(cmsg),
    .O_RENEW_MSG(rmsg), .O_FLASH_REQ(freq), .I_FLASH_DONE(fdone),
    .O_SAVING(saving), .O_IRQ(irq)
  );

  rci_flash_model rci_flash_model_inst (
    .i_clk(clk), .i_reset_n(rst_n), .i_flash_req(freq),
    .i_delay(fdelay), .o_flash_done(fdone)
  );

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    bresp_q = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rdata_q = rdata;
    rresp_q = rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `TB_CHK($sformatf("reg %h", a), e, rdata_q)
  endtask

  task automatic proc_run(input logic [2:0] ok, input logic [15:0] t,
                          input logic [15:0] tp);
    proc <= {ok, t, tp};
    pdone <= 1'h1;
    @(posedge clk);
    pdone <= 1'h0;
    @(posedge clk);
  endtask

  task automatic sel(input rci_view_t v);
    vcode <= v;
    vsel <= 1'h1;
    @(posedge clk);
    vsel <= 1'h0;
    @(posedge clk);
  endtask

  task automatic key(input logic up);
    if (up) kup <= 1'h1;
    else kdn <= 1'h1;
    @(posedge clk);
    kup <= 1'h0;
    kdn <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    while (freq) begin
      `TB_CHK("saving", 1'h1, saving)
      @(posedge clk);
    end
    `TB_CHK("saving", 1'h0, saving)
  endtask

  // Countdown k (0 cleaning, 1 renewal) with stop or continue action
  task automatic cd(input int k, input logic act);
    logic [7:0] off;
    logic [31:0] c;
    off = k ? `RCI_OFF_RENEW : `RCI_OFF_CLEAN;
    c = 32'h0;
    c[2*k] = 1'h1;
    c[2*k+1] = act;
    wr(`RCI_OFF_CTRL, c);
    wr(off, 32'h2);
    proc_run(3'h7, 16'h0, 16'h0);
    rc(off, 32'h1);
    `TB_CHK("msg", 1'h0, k ? rmsg : cmsg)
    wr(`RCI_OFF_IRQ_STAT, 32'hf);
    proc_run(3'h7, 16'h0, 16'h0);
    `TB_CHK("msg", 1'h1, k ? rmsg : cmsg)
    `TB_CHK("ready", act, ready)
    sreq <= 1'h1;
    @(posedge clk);
    `TB_CHK("grant", act, grant)
    sreq <= 1'h0;
    if (act) begin
      wr(`RCI_OFF_IRQ_STAT, 32'hf);
      proc_run(3'h7, 16'h0, 16'h0);
      rc(`RCI_OFF_IRQ_STAT, 32'h1 | (32'h2 << k));
      `TB_CHK("msg", 1'h1, k ? rmsg : cmsg)
    end
    rc(off, 32'h0);
    wr(off, 32'h000f423f);
    rc(off, 32'h000f423f);
    `TB_CHK("msg", 1'h0, k ? rmsg : cmsg)
    `TB_CHK("ready", 1'h1, ready)
    wr(`RCI_OFF_CTRL, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rc(`RCI_OFF_CTRL, 32'h70);
    rc(`RCI_OFF_PROFILE, 32'h1);
    rc(`RCI_OFF_CLEAN, 32'h000f423f);
    rc(`RCI_OFF_RENEW, 32'h000f423f);
    rc(`RCI_OFF_USAGE, 32'h0);
    rd(8'h40);
    `TB_CHK("rresp", `RCI_RESP_SLVERR, rresp_q)
    wr(8'h40, 32'h1);
    `TB_CHK("bresp", `RCI_RESP_SLVERR, bresp_q)
    wr(`RCI_OFF_USAGE, 32'h0098967f);
    wr(`RCI_OFF_GOOD, 32'h0098967f);
    proc_run(3'h7, 16'h1234, 16'h0abc);
    rc(`RCI_OFF_USAGE, 32'h0);
    rc(`RCI_OFF_GOOD, 32'h0);
    rc(`RCI_OFF_LAST_TIME, 32'h1234);
    rc(`RCI_OFF_LAST_TEMP, 32'h0abc);
    `TB_CHK("irq", 1'h0, irq)
    for (int i = 0; i < 3; i++) proc_run(3'h7 ^ (3'h1 << i), 16'h0, 16'h0);
    rc(`RCI_OFF_USAGE, 32'h3);
    rc(`RCI_OFF_GOOD, 32'h0);
    wr(`RCI_OFF_USAGE, 32'h0fffffff);
    rc(`RCI_OFF_USAGE, 32'h0098967f);
    wstrb <= 4'h1;
    wr(`RCI_OFF_USAGE, 32'hffffff00);
    wstrb <= 4'hf;
    rc(`RCI_OFF_USAGE, 32'h00989600);
    wr(`RCI_OFF_CTRL, 32'h0);
    wr(`RCI_OFF_IRQ_MASK, 32'h1);
    wr(`RCI_OFF_IRQ_STAT, 32'hf);
    proc_run(3'h0, 16'h0, 16'h0);
    rc(`RCI_OFF_GOOD, 32'h1);
    `TB_CHK("irq", 1'h1, irq)
    wr(`RCI_OFF_IRQ_STAT, 32'h1);
    `TB_CHK("irq", 1'h0, irq)
    wr(`RCI_OFF_IRQ_MASK, 32'h0);
    for (int k = 0; k < 2; k++) begin
      for (int a = 0; a < 2; a++) cd(k, a[0]);
    end
    sel(VIEW_GRAPH);
    wait_idle();
    key(1'h0);
    rc(`RCI_OFF_PROFILE, 32'h3f);
    key(1'h1);
    rc(`RCI_OFF_PROFILE, 32'h1);
    sel(VIEW_COUNTERS);
    wait_idle();
    key(1'h1);
    rc(`RCI_OFF_PROFILE, 32'h1);
    sel(VIEW_DATA);
    wait_idle();
    key(1'h1);
    wait_idle();
    rd(`RCI_OFF_STATUS);
    `TB_CHK("view", 3'h0, rdata_q[2:0])
    rc(`RCI_OFF_PROFILE, 32'h1);
    key(1'h1);
    rc(`RCI_OFF_PROFILE, 32'h2);
    for (int v = 0; v < 6; v++) begin
      sel(rci_view_t'(v));
      wait_idle();
      sreq <= 1'h1;
      @(posedge clk);
      `TB_CHK("grant", v < 2, grant)
      sreq <= 1'h0;
    end
    fdelay <= 4'h5;
    wr(`RCI_OFF_PROFILE, 32'h4);
    sel(VIEW_MENU);
    `TB_CHK("freq", 1'h0, freq)
    for (int v = 0; v < 5; v++) begin
      wr(`RCI_OFF_PROFILE, 32'h5 + v);
      sel(rci_view_t'(v));
      `TB_CHK("freq", 1'h1, freq)
      wait_idle();
    end
    rd(`RCI_OFF_IRQ_STAT);
    `TB_CHK("saved", 1'h1, rdata_q[3])
    give_verdict();
  end
endmodule // tb_reflow_counter_interlock
`default_nettype wire
